// File: pbmr_pkg.sv
//==============================================================================
// Functional notes
// - registers reached only via indirect index port
// - kept fields survive soft reset only
// - control bit 15 starts self-clearing soft reset
// - control bit 14 selects loopback, resets 0
// - bit 13 forces 100M, ignored under negotiation
// - bit 12 enables negotiation, overriding forced modes
// - speed and negotiation defaults follow speed strap
// - bit 11 powers down, clearing resumes operation
// - after power-down negotiation restarts, sets status 5
// - bit 9 restarts negotiation and self-clears
// - bit 8 forces full duplex, ignored under negotiation
// - bit 7 enables collision signal test
// - status 15 reads 0, bits 14-11 read 1
// - status 5 shows negotiation complete, read-only
// - status 4 remote fault, latching high
// - status 3 reads constant 1
// - status 2 link, latching low
// - status 1 jabber, latching high
// - status 0 reads constant 1
//==============================================================================
package pbmr_pkg;
    //==========================================================================
    // register indexes
    localparam logic [4:0] IDX_BASIC_CONTROL    = 5'h00;
    localparam logic [4:0] IDX_BASIC_STATUS     = 5'h01;
    localparam logic [4:0] IDX_ID_HIGH          = 5'h02;
    localparam logic [4:0] IDX_ID_LOW           = 5'h03;
    localparam logic [4:0] IDX_NEG_ADVERTISE    = 5'h04;
    localparam logic [4:0] IDX_PARTNER_ABILITY  = 5'h05;
    localparam logic [4:0] IDX_NEG_EXPANSION    = 5'h06;
    localparam logic [4:0] IDX_MODE_CTRL_STAT   = 5'h11;
    localparam logic [4:0] IDX_SPECIAL_MODES    = 5'h12;
    localparam logic [4:0] IDX_SPECIAL_IND      = 5'h1B;
    localparam logic [4:0] IDX_IRQ_SOURCE       = 5'h1D;
    localparam logic [4:0] IDX_IRQ_MASK         = 5'h1E;
    localparam logic [4:0] IDX_SPECIAL_CTRL     = 5'h1F;

    //==========================================================================
    // control field positions
    localparam int unsigned CB_SOFT_RESET = 15;
    localparam int unsigned CB_LOOPBACK   = 14;
    localparam int unsigned CB_SPEED_100  = 13;
    localparam int unsigned CB_NEG_ENABLE = 12;
    localparam int unsigned CB_POWER_DOWN = 11;
    localparam int unsigned CB_NEG_RESTART = 9;
    localparam int unsigned CB_FULL_DUPLEX = 8;
    localparam int unsigned CB_COL_TEST   = 7;

    //==========================================================================
    // status field positions and fixed ability bits
    localparam int unsigned SB_NEG_DONE     = 5;
    localparam int unsigned SB_REMOTE_FAULT = 4;
    localparam int unsigned SB_LINK_UP      = 2;
    localparam int unsigned SB_JABBER       = 1;
    localparam logic [15:0] STATUS_FIXED    = 16'h7809;

    //==========================================================================
    // reset values; strap-driven bits are loaded separately
    localparam logic [15:0] CTRL_RESET      = 16'h0000;
    // fields kept over soft reset; none in the basic control word
    localparam logic [15:0] CTRL_KEPT_MASK  = 16'h0000;

    //==========================================================================
    // latch bank: bit 0 remote fault, 1 link, 2 jabber
    localparam int unsigned LAT_FAULT  = 0;
    localparam int unsigned LAT_LINK   = 1;
    localparam int unsigned LAT_JABBER = 2;
    localparam logic [2:0]  LAT_HIGH_MASK = 3'h5;

    //==========================================================================
    // timing
    localparam int unsigned MCLK_PERIOD_PS = 25000;
    localparam int unsigned SRST_TIME_NS   = 250;
    localparam int unsigned SRST_CYCLES    =
        (SRST_TIME_NS * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;

    typedef enum logic {srst_idle, srst_busy} pbmr_srst_t;

    // true for any index the map defines
    function automatic logic pbmr_index_defined(input logic [4:0] idx);
        return (idx <= IDX_NEG_EXPANSION) || (idx == IDX_MODE_CTRL_STAT) ||
               (idx == IDX_SPECIAL_MODES) || (idx == IDX_SPECIAL_IND) ||
               (idx >= IDX_IRQ_SOURCE);
    endfunction
endpackage

// File: pbmr_latch_if.sv
`timescale 1ns/1ps
//==============================================================================
// carrier between the register file and its latch bank
interface pbmr_latch_if;
    logic [2:0] live;
    logic [2:0] latched;
    logic       clear;
    logic       srst;
    modport owner (output live, output clear, output srst, input latched);
    modport bank  (input live, input clear, input srst, output latched);
endinterface

// File: pbmr_latch_bank.sv
`timescale 1ns/1ps
//==============================================================================
// latching-high / latching-low status bits
module pbmr_latch_bank
    import pbmr_pkg::*;
#(
    parameter int         WIDTH     = 3,
    parameter logic [2:0] HIGH_MASK = pbmr_pkg::LAT_HIGH_MASK
) (
    input  wire logic  mclk,
    input  wire logic  rst_n,
    pbmr_latch_if.bank lat
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    //==========================================================================
    // one latch per bit; a live event in the clear cycle still sets
    for (genvar i = 0; i < WIDTH; i++) begin : g_lat
        logic q;
        always_ff @(posedge mclk) begin
            if (!rst_n || lat.srst) begin
                q <= 1'b0;
            end else if (HIGH_MASK[i]) begin
                q <= lat.live[i] | (q & ~lat.clear);
            end else begin
                q <= lat.live[i] & (q | lat.clear);
            end
        end
        assign lat.latched[i] = q;

        if (HIGH_MASK[i]) begin : g_hi
            AST_LH_STAYS: assert property (q && !lat.clear && !lat.srst |=> q)
                else $error("latched-high bit dropped without a read");
        end else begin : g_lo
            AST_LL_STAYS: assert property (!q && !lat.clear |=> !q)
                else $error("latched-low bit rose without a read");
        end
        AST_READ_LIVE: assert property (
            lat.clear && !lat.srst |=> q == $past(lat.live[i]))
            else $error("latched bit did not return to live after read");
    end
endmodule // pbmr_latch_bank

// File: pbmr_basic_regs.sv
`timescale 1ns/1ps
//==============================================================================
// basic control / status register pair behind the indirect access port
module pbmr_basic_regs
    import pbmr_pkg::*;
#(
    parameter int unsigned SRST_LEN = pbmr_pkg::SRST_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // indirect management port from the access logic
    input  wire logic [4:0]  mgmt_index,
    input  wire logic        mgmt_wr,
    input  wire logic        mgmt_rd,
    input  wire logic [15:0] mgmt_wdata,
    output logic [15:0]      mgmt_rdata,
    output logic             mgmt_rvalid,
    // line side
    input  wire logic        speed_strap,
    input  wire logic        link_live,
    input  wire logic        remote_fault_live,
    input  wire logic        jabber_live,
    input  wire logic        neg_done_live,
    input  wire logic        neg_result_100,
    input  wire logic        neg_result_full,
    // control outputs
    output logic             loopback_en,
    output logic             power_down,
    output logic             col_test_en,
    output logic             neg_enable,
    output logic             neg_restart,
    output logic             soft_reset_busy,
    output logic             mode_speed_100,
    output logic             mode_full_duplex
);
    import pbmr_pkg::*;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    localparam logic [7:0] SRST_LOAD = 8'(SRST_LEN - 1);

    pbmr_srst_t  srst_q;
    logic [7:0]  srst_cnt_q;
    logic        strap_load_q;
    logic        loopback_q;
    logic        speed_q;
    logic        neg_en_q;
    logic        pwr_dn_q;
    logic        restart_q;
    logic        duplex_q;
    logic        col_test_q;
    logic        mode_speed_q;
    logic        mode_full_q;
    logic [15:0] rdata_q;
    logic        rvalid_q;
    logic        ctrl_wr;
    logic        srst_go;
    logic        neg_done;
    logic        restart_evt;
    logic [15:0] ctrl_word;
    logic [15:0] status_word;
    logic [15:0] rd_mux;

    pbmr_latch_if lat ();

    //==========================================================================
    // write decode; writes are dropped while the soft reset runs
    assign ctrl_wr = mgmt_wr && (mgmt_index == IDX_BASIC_CONTROL)
                     && (srst_q == srst_idle) && !strap_load_q;
    assign srst_go = ctrl_wr && mgmt_wdata[CB_SOFT_RESET];

    //==========================================================================
    // soft reset sequencer, self-clears after a fixed count
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            srst_q     <= srst_idle;
            srst_cnt_q <= 8'h00;
        end else begin
            unique case (srst_q)
                srst_idle: begin
                    if (srst_go) begin
                        srst_q     <= srst_busy;
                        srst_cnt_q <= SRST_LOAD;
                    end
                end
                srst_busy: begin
                    if (srst_cnt_q == 8'h00) begin
                        srst_q <= srst_idle;
                    end else begin
                        srst_cnt_q <= srst_cnt_q - 8'h01;
                    end
                end
            endcase
        end
    end

    // checks: busy clears within 64 cycles, and a write inside it is
    // dropped so a host cannot half-configure a resetting port
    AST_SRST_SELF_CLEARS: assert property (
        $rose(soft_reset_busy) |-> ##[1:64] !soft_reset_busy)
        else $error("soft reset bit never cleared");
    AST_SRST_WR_REFUSED: assert property (
        soft_reset_busy && mgmt_wr |=>
        $stable({loopback_q, speed_q, neg_en_q, pwr_dn_q, duplex_q, col_test_q}))
        else $error("control write took effect during soft reset");

    //==========================================================================
    // strap is caught on the first edge after reset release
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            strap_load_q <= 1'b1;
        end else begin
            strap_load_q <= 1'b0;
        end
    end

    //==========================================================================
    // strap-defaulted fields: speed and negotiation enable
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            speed_q  <= CTRL_RESET[CB_SPEED_100];
            neg_en_q <= CTRL_RESET[CB_NEG_ENABLE];
        end else if (strap_load_q) begin
            speed_q  <= speed_strap;
            neg_en_q <= speed_strap;
        end else if (srst_go) begin
            // kept fields hold only across the soft reset
            speed_q  <= CTRL_KEPT_MASK[CB_SPEED_100] ? speed_q : speed_strap;
            neg_en_q <= CTRL_KEPT_MASK[CB_NEG_ENABLE] ? neg_en_q : speed_strap;
        end else if (ctrl_wr) begin
            speed_q  <= mgmt_wdata[CB_SPEED_100];
            neg_en_q <= mgmt_wdata[CB_NEG_ENABLE];
        end
    end

    // checks: strap feeds the negotiation default at power-up and both defaults again on soft reset;
    // the reload is not a keep, the kept mask is empty for this word
    AST_STRAP_LOAD: assert property (
        strap_load_q |=> neg_enable == $past(speed_strap))
        else $error("negotiation default not taken from strap");
    AST_SRST_STRAP_RELOAD: assert property (
        srst_go |=> speed_q == $past(speed_strap) && neg_en_q == $past(speed_strap))
        else $error("soft reset did not reload strap defaults");

    //==========================================================================
    // plain read/write control fields
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            loopback_q <= CTRL_RESET[CB_LOOPBACK];
            pwr_dn_q   <= CTRL_RESET[CB_POWER_DOWN];
            duplex_q   <= CTRL_RESET[CB_FULL_DUPLEX];
            col_test_q <= CTRL_RESET[CB_COL_TEST];
        end else if (srst_go) begin
            loopback_q <= CTRL_KEPT_MASK[CB_LOOPBACK] ? loopback_q :
                          CTRL_RESET[CB_LOOPBACK];
            pwr_dn_q   <= CTRL_KEPT_MASK[CB_POWER_DOWN] ? pwr_dn_q :
                          CTRL_RESET[CB_POWER_DOWN];
            duplex_q   <= CTRL_KEPT_MASK[CB_FULL_DUPLEX] ? duplex_q :
                          CTRL_RESET[CB_FULL_DUPLEX];
            col_test_q <= CTRL_KEPT_MASK[CB_COL_TEST] ? col_test_q :
                          CTRL_RESET[CB_COL_TEST];
        end else if (ctrl_wr) begin
            loopback_q <= mgmt_wdata[CB_LOOPBACK];
            pwr_dn_q   <= mgmt_wdata[CB_POWER_DOWN];
            duplex_q   <= mgmt_wdata[CB_FULL_DUPLEX];
            col_test_q <= mgmt_wdata[CB_COL_TEST];
        end
    end

    // checks: soft reset returns loopback, power down and collision test to their
    // reset values, and a write not carrying bit 15 lands in each of those three fields
    AST_SRST_DEFAULTS: assert property (
        srst_go |=> !loopback_q && !pwr_dn_q && !col_test_q)
        else $error("soft reset left a control field set");
    AST_LOOPBACK_WRITE: assert property (
        ctrl_wr && !srst_go |=> loopback_en == $past(mgmt_wdata[14]))
        else $error("loopback did not follow write");
    AST_PWRDN_WRITE: assert property (
        ctrl_wr && !srst_go |=> power_down == $past(mgmt_wdata[11]))
        else $error("power down did not follow write");
    AST_COLTEST_WRITE: assert property (
        ctrl_wr && !srst_go |=> col_test_en == $past(mgmt_wdata[7]))
        else $error("collision test did not follow write");

    //==========================================================================
    // negotiation restart: explicit request, enable turned on, or
    // power-down released with negotiation on; held one cycle
    assign restart_evt = ctrl_wr && !srst_go &&
                         (mgmt_wdata[CB_NEG_RESTART] ||
                          (mgmt_wdata[CB_NEG_ENABLE] && !neg_en_q) ||
                          (pwr_dn_q && !mgmt_wdata[CB_POWER_DOWN] &&
                           mgmt_wdata[CB_NEG_ENABLE]));

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            restart_q <= 1'b0;
        end else begin
            restart_q <= restart_evt;
        end
    end

    // checks: restart is a single-cycle pulse; leaving power-down with
    // negotiation on must also kick it, or status bit 5 never comes back
    AST_RESTART_PULSE: assert property (
        restart_q |=> !restart_q)
        else $error("restart bit did not self-clear");
    AST_PD_RELEASE_RESTART: assert property (
        ctrl_wr && !srst_go && pwr_dn_q && !mgmt_wdata[CB_POWER_DOWN] &&
        mgmt_wdata[CB_NEG_ENABLE] |=> neg_restart)
        else $error("power-down release did not restart negotiation");

    //==========================================================================
    // effective mode: forced bits count only with negotiation off
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mode_speed_q <= 1'b0;
            mode_full_q  <= 1'b0;
        end else if (neg_en_q) begin
            mode_speed_q <= neg_result_100;
            mode_full_q  <= neg_result_full;
        end else begin
            mode_speed_q <= speed_q;
            mode_full_q  <= duplex_q;
        end
    end

    // checks: forced bits steer the mode only with negotiation off; the
    // mode lags the control bits by one cycle
    AST_SPEED_IGNORED: assert property (
        neg_en_q |=> mode_speed_100 == $past(neg_result_100))
        else $error("forced speed used under negotiation");
    AST_DUPLEX_FORCED: assert property (
        !neg_en_q |=> mode_full_duplex == $past(duplex_q))
        else $error("forced duplex not applied");
    AST_NEG_OVERRIDES: assert property (
        neg_en_q |=> mode_full_duplex == $past(neg_result_full))
        else $error("negotiation did not override duplex");

    //==========================================================================
    // latch bank hookup; a status read re-arms the latches
    assign lat.live[LAT_FAULT]  = remote_fault_live;
    assign lat.live[LAT_LINK]   = link_live;
    assign lat.live[LAT_JABBER] = jabber_live;
    assign lat.clear = mgmt_rd && (mgmt_index == IDX_BASIC_STATUS);
    assign lat.srst  = srst_go;

    pbmr_latch_bank #(
        .WIDTH     (3),
        .HIGH_MASK (LAT_HIGH_MASK)
    ) u_latch (
        .mclk  (mclk),
        .rst_n (rst_n),
        .lat   (lat)
    );

    //==========================================================================
    // read words; reserved bits stay zero
    assign neg_done = neg_en_q && !pwr_dn_q && !restart_q && neg_done_live;

    always_comb begin
        ctrl_word                 = 16'h0000;
        ctrl_word[CB_SOFT_RESET]  = (srst_q == srst_busy);
        ctrl_word[CB_LOOPBACK]    = loopback_q;
        ctrl_word[CB_SPEED_100]   = speed_q;
        ctrl_word[CB_NEG_ENABLE]  = neg_en_q;
        ctrl_word[CB_POWER_DOWN]  = pwr_dn_q;
        ctrl_word[CB_NEG_RESTART] = restart_q;
        ctrl_word[CB_FULL_DUPLEX] = duplex_q;
        ctrl_word[CB_COL_TEST]    = col_test_q;
    end

    always_comb begin
        status_word                  = STATUS_FIXED;
        status_word[SB_NEG_DONE]     = neg_done;
        status_word[SB_REMOTE_FAULT] = lat.latched[LAT_FAULT];
        status_word[SB_LINK_UP]      = lat.latched[LAT_LINK];
        status_word[SB_JABBER]       = lat.latched[LAT_JABBER];
    end

    // other defined indexes live outside this block and read zero here
    always_comb begin
        if (mgmt_index == IDX_BASIC_CONTROL) begin
            rd_mux = ctrl_word;
        end else if (mgmt_index == IDX_BASIC_STATUS) begin
            rd_mux = status_word;
        end else begin
            rd_mux = pbmr_index_defined(mgmt_index) ? 16'h0000 : 16'h0000;
        end
    end

    //==========================================================================
    // read answer one cycle after the strobe
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_q  <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= mgmt_rd;
            if (mgmt_rd) begin
                rdata_q <= rd_mux;
            end
        end
    end

    // checks on the read answer, judged from the bus side so a broken
    // mux or latch hookup shows up here and not only inside
    AST_STATUS_FIXED: assert property (
        mgmt_rd && mgmt_index == 5'h01 |=>
        mgmt_rdata[15:11] == 5'h0F && mgmt_rdata[3] && mgmt_rdata[0] &&
        mgmt_rdata[10:6] == 5'h00)
        else $error("status ability bits wrong");
    AST_NEG_DONE_GATED: assert property (
        mgmt_rd && mgmt_index == 5'h01 && !neg_en_q |=> !mgmt_rdata[5])
        else $error("negotiation complete shown while disabled");
    AST_CTRL_RSVD: assert property (
        mgmt_rd && mgmt_index == 5'h00 |=> mgmt_rdata[6:0] == 7'h00 && !mgmt_rdata[10])
        else $error("reserved control bits not zero");
    AST_RVALID: assert property (
        mgmt_rd |=> mgmt_rvalid ##1 !mgmt_rvalid || $past(mgmt_rd))
        else $error("read answer timing wrong");

    assign mgmt_rdata       = rdata_q;
    assign mgmt_rvalid      = rvalid_q;
    assign loopback_en      = loopback_q;
    assign power_down       = pwr_dn_q;
    assign col_test_en      = col_test_q;
    assign neg_enable       = neg_en_q;
    assign neg_restart      = restart_q;
    assign soft_reset_busy  = (srst_q == srst_busy);
    assign mode_speed_100   = mode_speed_q;
    assign mode_full_duplex = mode_full_q;

    //==========================================================================
    // scenario covers; each marks a path the bench is meant to walk
    COV_WR_REFUSED: cover property (soft_reset_busy && mgmt_wr ##1 soft_reset_busy);

    COV_SOFT_RESET: cover property (srst_go ##1 soft_reset_busy [*3]);
    COV_STATUS_READ: cover property (lat.clear ##1 mgmt_rvalid);
    COV_RESTART: cover property (restart_q ##1 !restart_q);
    COV_PWRDN_RELEASE: cover property (pwr_dn_q ##1 !pwr_dn_q && neg_en_q);
endmodule // pbmr_basic_regs

// File: pbmr_mac_model.sv
`timescale 1ns/1ps
//==============================================================================
// mac-side indirect management master
module pbmr_mac_model (
    input  wire logic        go,
    input  wire logic        go_wr,
    input  wire logic [4:0]  go_index,
    input  wire logic [15:0] go_wdata,
    output logic [4:0]       mgmt_index,
    output logic             mgmt_wr,
    output logic             mgmt_rd,
    output logic [15:0]      mgmt_wdata
);
    // one strobe per request; registers reached only through index
    assign mgmt_wr    = go & go_wr;
    assign mgmt_rd    = go & ~go_wr;
    // idle lines invert so a stale value never looks valid
    assign mgmt_index = go ? go_index : ~go_index;
    assign mgmt_wdata = go ? go_wdata : ~go_wdata;
endmodule // pbmr_mac_model

// File: pbmr_basic_regs_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
//==============================================================================
// self-checking bench for the basic control / status pair
module pbmr_basic_regs_tb;
    import pbmr_pkg::*;
    localparam int unsigned SRST = 4; // short soft reset keeps the run brief
    logic        mclk = 1'h0, rst_n = 1'h0, go = 1'h0, go_wr = 1'h0, strap = 1'h1;
    logic        link = 1'h0, fault = 1'h0, jab = 1'h0, done = 1'h0;
    logic        r100 = 1'h0, rfull = 1'h0;
    logic [4:0]  go_index = 5'h00;
    logic [15:0] go_wdata = 16'h0000;
    logic [4:0]  mgmt_index;
    logic [15:0] mgmt_wdata, rdata;
    logic        mgmt_wr, mgmt_rd, rvalid, lpbk, pdn, col, neg_en, restart, busy, m100, mfull;
    int          n_mismatch = 0, n_compared = 0, cycles = 0, ticks = 0;

    pbmr_mac_model i_pbmr_mac_model (.go(go), .go_wr(go_wr), .go_index(go_index),
        .go_wdata(go_wdata), .mgmt_index(mgmt_index), .mgmt_wr(mgmt_wr),
        .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata));

    pbmr_basic_regs #(.SRST_LEN(SRST)) i_pbmr_basic_regs (.mclk(mclk), .rst_n(rst_n),
        .mgmt_index(mgmt_index), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
        .mgmt_wdata(mgmt_wdata), .mgmt_rdata(rdata), .mgmt_rvalid(rvalid),
        .speed_strap(strap), .link_live(link), .remote_fault_live(fault),
        .jabber_live(jab), .neg_done_live(done), .neg_result_100(r100),
        .neg_result_full(rfull), .loopback_en(lpbk), .power_down(pdn),
        .col_test_en(col), .neg_enable(neg_en), .neg_restart(restart),
        .soft_reset_busy(busy), .mode_speed_100(m100), .mode_full_duplex(mfull));

    //==========================================================================
    // clock and cycle ceiling
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    // a hung wait ends the run as a mismatch
    always @(posedge mclk) begin
        ticks++;
        if (ticks == 2000) begin
            n_mismatch++;
            finish_test();
        end
    end

    //==========================================================================
    // one strobe via the model after an idle edge, so go never falls and
    // rises in one time step; reads judge the answer while rvalid stands
    task automatic acc(input logic w, input logic [4:0] i, input logic [15:0] d, input string nm);
        @(posedge mclk) #1;
        go = 1'h1;
        go_wr = w;
        go_index = i;
        go_wdata = d;
        @(posedge mclk) #1;
        go = 1'h0;
        if (!w) begin
            `CHK({nm, " valid"}, 1'h1, rvalid)
            `CHK(nm, d, rdata)
        end
    endtask

    task automatic t_defaults();
        acc(1'h0, IDX_BASIC_CONTROL, 16'h3000, "ctrl default");
        acc(1'h0, IDX_BASIC_STATUS, 16'h7809, "status");
        acc(1'h0, IDX_ID_HIGH, 16'h0000, "index 2");
        $display("TB: defaults done");
    endtask

    task automatic t_forced();
        acc(1'h1, IDX_BASIC_CONTROL, 16'h6DFF, "");
        acc(1'h0, IDX_BASIC_CONTROL, 16'h6980, "ctrl forced");
        `CHK("loopback", 1'h1, lpbk)
        `CHK("power down", 1'h1, pdn)
        `CHK("col test", 1'h1, col)
        `CHK("speed", 1'h1, m100)
        `CHK("duplex", 1'h1, mfull)
        acc(1'h1, IDX_BASIC_CONTROL, 16'h0000, "");
        acc(1'h0, IDX_BASIC_CONTROL, 16'h0000, "ctrl clear");
        `CHK("speed 10", 1'h0, m100)
        `CHK("col off", 1'h0, col)
        $display("TB: forced modes done");
    endtask

    task automatic t_neg();
        acc(1'h1, IDX_BASIC_CONTROL, 16'h3100, "");
        done = 1'h1;
        acc(1'h0, IDX_BASIC_CONTROL, 16'h3100, "ctrl neg");
        `CHK("neg enable", 1'h1, neg_en)
        `CHK("speed neg", 1'h0, m100)
        `CHK("duplex neg", 1'h0, mfull)
        acc(1'h0, IDX_BASIC_STATUS, 16'h7829, "neg done");
        acc(1'h1, IDX_BASIC_CONTROL, 16'h3300, "");
        `CHK("restart", 1'h1, restart)
        acc(1'h0, IDX_BASIC_CONTROL, 16'h3100, "restart clr");
        `CHK("restart end", 1'h0, restart)
        $display("TB: negotiation done");
    endtask

    task automatic t_power();
        acc(1'h1, IDX_BASIC_CONTROL, 16'h3900, "");
        acc(1'h0, IDX_BASIC_STATUS, 16'h7809, "pd status");
        `CHK("pd on", 1'h1, pdn)
        acc(1'h1, IDX_BASIC_CONTROL, 16'h3100, "");
        `CHK("pd off", 1'h0, pdn)
        `CHK("pd restart", 1'h1, restart)
        $display("TB: power down done");
    endtask

    task automatic t_latch();
        @(posedge mclk) #1;
        link = 1'h1;
        acc(1'h0, IDX_BASIC_STATUS, 16'h7829, "link held");
        acc(1'h0, IDX_BASIC_STATUS, 16'h782D, "link up");
        link = 1'h0;
        fault = 1'h1;
        jab = 1'h1;
        @(posedge mclk) #1;
        link = 1'h1;
        fault = 1'h0;
        jab = 1'h0;
        acc(1'h0, IDX_BASIC_STATUS, 16'h783B, "latched");
        acc(1'h0, IDX_BASIC_STATUS, 16'h782D, "rearmed");
        $display("TB: latches done");
    endtask

    task automatic t_srst();
        strap = 1'h0;
        acc(1'h1, IDX_BASIC_CONTROL, 16'h8000, "");
        `CHK("busy", 1'h1, busy)
        acc(1'h1, IDX_BASIC_CONTROL, 16'h4000, "");
        // the reset write and the refused write already spent two edges
        cycles = 2;
        while (busy === 1'h1 && cycles < 50) begin
            cycles++;
            @(posedge mclk) #1;
        end
        `CHK("busy length", SRST, cycles)
        acc(1'h0, IDX_BASIC_CONTROL, 16'h0000, "ctrl srst");
        `CHK("loopback srst", 1'h0, lpbk)
        $display("TB: soft reset done");
    endtask

    task automatic finish_test();
        $display("TB: %0d compared, %0d mismatched", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    //==========================================================================
    // reset, then one pass through the scenarios
    initial begin
        repeat (6) @(posedge mclk);
        #1;
        rst_n = 1'h1;
        repeat (2) @(posedge mclk);
        #1;
        t_defaults();
        t_forced();
        t_neg();
        t_power();
        t_latch();
        t_srst();
        finish_test();
    end
endmodule // pbmr_basic_regs_tb
